// ===== design/epa_pkg.sv
// Package for the emulated PHY management register bank
package epa_pkg;

    // ****************************************
    // Register addresses on the management link
    // ****************************************
    localparam logic [4:0] REG_BASIC_CONTROL = 5'h00;
    localparam logic [4:0] REG_BASIC_STATUS = 5'h01;
    localparam logic [4:0] REG_ID_HIGH = 5'h02;
    localparam logic [4:0] REG_ID_LOW = 5'h03;
    localparam logic [4:0] REG_ADVERTISE = 5'h04;
    localparam logic [4:0] REG_PARTNER = 5'h05;
    localparam logic [4:0] REG_EXPANSION = 5'h06;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int BC_SOFT_RESET = 15;
    localparam int BC_SPEED = 13;
    localparam int BC_AUTONEG = 12;
    localparam int BC_RESTART = 9;
    localparam int BC_DUPLEX = 8;
    localparam int BS_AN_COMPLETE = 5;
    localparam int EX_PAGE_RX = 1;
    localparam int EX_PARTNER_ABLE = 0;
    localparam int ADV_SYM_PAUSE = 10;
    localparam int ADV_ASYM_PAUSE = 11;
    localparam int ADV_TECH_LSB = 5;
    localparam int RC_DIGITAL_RST = 10;
    localparam int RC_PHY_RST = 3;
    localparam int PM_PHY_RST = 10;
    localparam int MF_SELECT = 0;

    // ****************************************
    // Reset values and fixed contents
    // ****************************************
    localparam logic [15:0] BASIC_CONTROL_RST = 16'h3100;
    localparam logic [15:0] BASIC_STATUS_FIXED = 16'h7808;
    localparam logic [15:0] ADVERTISE_RST = 16'h01E1;
    localparam logic [15:0] ADV_WRITE_MASK = 16'h0DE0;
    localparam logic [3:0] PARTNER_TECH_ALL = 4'hF;
    localparam logic [3:0] PARALLEL_TECH = 4'h4;
    localparam logic [4:0] SELECTOR_8023 = 5'h01;
    localparam logic [15:0] UNMAPPED_READ = 16'hFFFF;
    // Identity words are arbitrary neutral values
    localparam logic [15:0] ID_HIGH_VALUE = 16'h0000;
    localparam logic [15:0] ID_LOW_VALUE = 16'h0000;
    localparam logic [4:0] PHY_ADDRESS_RST = 5'h00;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLOCK_MHZ = 125;
    localparam int SOFT_RESET_US = 102;
    localparam int SOFT_RESET_CYCLES = SOFT_RESET_US * CLOCK_MHZ;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        OP_WRITE = 2'h1,
        OP_READ = 2'h2
    } epa_op_t;

    typedef struct packed {
        logic speed_100;
        logic full_duplex;
        logic tx_pause;
        logic rx_pause;
    } epa_link_t;

endpackage : epa_pkg

// ===== design/epa_core.sv
// Emulated PHY register bank with a clause 22 management slave
// Functional notes
// [RULE_01] Offer standard clause 22 registers over the management link like one PHY.
// [RULE_02] Basic control bit 12 enables emulated negotiation.
// [RULE_03] Writing basic control bit 9 restarts negotiation.
// [RULE_04] Resets, soft resets, digital reset and reload all restart negotiation.
// [RULE_05] Step one sets status bit 5, negotiation complete.
// [RULE_06] Step two sets page received; step three latches speed and duplex.
// [RULE_07] Result is AND of abilities, priority 100F, 100H, 10F, 10H.
// [RULE_08] Advertisement resets with all four abilities set; software may rewrite.
// [RULE_09] Advertisement changes after completion wait for the next negotiation; code latches abilities only, pause bits 10 and 11 apply at once.
// [RULE_10] Emulated partner advertises all four abilities.
// [RULE_11] No next page, remote fault or T4 anywhere.
// [RULE_12] Common ability: set expansion bit 0, show partner abilities.
// [RULE_13] No common ability: clear bit 0, 100 half, one partner bit set.
// [RULE_14] Negotiation off: speed from bit 13, duplex from bit 8.
// [RULE_15] Negotiation on: forced speed and duplex bits ignored.
// [RULE_16] Advertised pause from advertisement bits 10 and 11.
// [RULE_17] Partner pause mirrors the advertised pause bits.
// [RULE_18] Manual flow setting used when negotiation off or select set; reports state.
// [RULE_19] Manual flow writes never touch advertised pause bits.
// [RULE_20] Reset control bit 3 resets the emulated PHY, clears after 102 us.
// [RULE_21] Basic control bit 15 resets the PHY and reads zero after.
// [RULE_22] Power control bit 10 resets the PHY, clears after 102 us.
// [RULE_23] Frames follow clause 22 format; the MAC drives the management clock.
`timescale 1ns/1ps
module epa_core
    import epa_pkg::*;
#(
    parameter int RESET_CYCLES = SOFT_RESET_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic hardware_reset_n,
    // Management link
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    // Chip level controls
    input wire logic digital_reset_req,
    input wire logic config_reload_req,
    input wire logic chip_rc_phy_reset_set,
    input wire logic pm_phy_reset_set,
    input wire logic [4:0] phy_address,
    // Host port manual flow control
    input wire logic [3:0] manual_flow_in,
    // Status
    output logic chip_rc_phy_reset,
    output logic pm_phy_reset,
    output epa_link_t link_state,
    output logic [3:0] host_port_manual_flow_reg
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    // Third clock stage feeds only the edge detector, never the logic
    logic [2:0] mdc_sync;
    logic [1:0] mdio_sync;
    logic [1:0] hw_sync;
    always_ff @(posedge clock) begin
        mdc_sync <= {mdc_sync[1:0], mdc};
        mdio_sync <= {mdio_sync[0], mdio_in};
        hw_sync <= {hw_sync[0], hardware_reset_n};
    end
    wire logic mdc_rise = mdc_sync[1] & ~mdc_sync[2];
    wire logic mdc_fall = ~mdc_sync[1] & mdc_sync[2];
    wire logic mdio_bit = mdio_sync[1];
    wire logic hw_reset = rst | ~hw_sync[1];

    // ****************************************
    // Soft reset timers
    // ****************************************
    localparam int TW = $clog2(RESET_CYCLES + 1);
    logic [TW-1:0] rc_count;
    logic [TW-1:0] pm_count;
    logic bc_reset_pulse;
    // A set request while the bit is already up neither restarts nor stretches it
    wire logic rc_start = chip_rc_phy_reset_set & ~chip_rc_phy_reset;
    wire logic pm_start = pm_phy_reset_set & ~pm_phy_reset;
    wire logic soft_reset = bc_reset_pulse | rc_start | pm_start;
    // Each bit stays up for RESET_CYCLES clocks, then clears itself
    always_ff @(posedge clock) begin
        if (hw_reset) begin
            rc_count <= '0;
            chip_rc_phy_reset <= 1'b0;
            pm_count <= '0;
            pm_phy_reset <= 1'b0;
        end else begin
            if (rc_start) begin
                chip_rc_phy_reset <= 1'b1; // see [RULE_20]
                rc_count <= TW'(RESET_CYCLES - 1);
            end else if (chip_rc_phy_reset) begin
                rc_count <= rc_count - 1'b1;
                if (rc_count == '0) chip_rc_phy_reset <= 1'b0;
            end
            if (pm_start) begin
                pm_phy_reset <= 1'b1; // see [RULE_22]
                pm_count <= TW'(RESET_CYCLES - 1);
            end else if (pm_phy_reset) begin
                pm_count <= pm_count - 1'b1;
                if (pm_count == '0) pm_phy_reset <= 1'b0;
            end
        end
    end
    // Registers return to defaults on any PHY reset; digital reset only renegotiates
    wire logic bank_reset = hw_reset | soft_reset; // see [RULE_21]

    // ****************************************
    // Management frame receiver
    // ****************************************
    logic [5:0] bit_count;
    logic [5:0] ones;
    logic [13:0] header;
    logic [15:0] shifter;
    logic in_frame;
    logic reading;
    logic wr_pulse;
    logic rd_load;
    // Header is start(2) op(2) phy(5) reg(5), MSB first
    wire logic [1:0] hdr_op = header[11:10];
    wire logic [4:0] hdr_phy = header[9:5];
    wire logic [4:0] hdr_reg = header[4:0];
    wire logic addr_hit = (hdr_phy == phy_address);
    logic [15:0] read_data;
    // Refused frames drop out at the turnaround and wait for a fresh preamble
    always_ff @(posedge clock) begin
        wr_pulse <= 1'b0;
        rd_load <= 1'b0;
        if (hw_reset) begin
            bit_count <= '0;
            ones <= '0;
            header <= '0;
            in_frame <= 1'b0;
            reading <= 1'b0;
        end else if (mdc_rise) begin
            if (!in_frame) begin
                // 32 ones of preamble, then the start pattern 01
                if (mdio_bit) ones <= (ones == 6'h3F) ? ones : ones + 1'b1;
                else if (ones >= 6'h20) begin
                    in_frame <= 1'b1; // see [RULE_23]
                    bit_count <= 6'h01;
                    header <= 14'h0000;
                    ones <= '0;
                end else ones <= '0;
            end else begin
                bit_count <= bit_count + 1'b1;
                if (bit_count < 6'h0E) header <= {header[12:0], mdio_bit};
                // Header is complete here, on the first turnaround bit
                if (bit_count == 6'h0E) begin
                    if (header[13:12] != 2'h1 || !addr_hit) in_frame <= 1'b0;
                    else if (hdr_op == OP_READ) begin
                        reading <= 1'b1;
                        rd_load <= 1'b1;
                    end else if (hdr_op != OP_WRITE) in_frame <= 1'b0;
                end
                if (!reading && bit_count >= 6'h10) shifter <= {shifter[14:0], mdio_bit};
                if (bit_count == 6'h1F) begin
                    in_frame <= 1'b0;
                    reading <= 1'b0;
                    wr_pulse <= ~reading;
                end
            end
        end
    end

    // ****************************************
    // Read shifter drives on falling management clock
    // ****************************************
    // Leading zero is the device's half of the turnaround, ahead of the data MSB
    logic [16:0] out_shift;
    always_ff @(posedge clock) begin
        if (hw_reset) begin
            out_shift <= '0;
            mdio_out <= 1'b0;
            mdio_oe <= 1'b0;
        end else begin
            if (rd_load) out_shift <= {1'b0, read_data};
            if (mdc_fall) begin
                mdio_oe <= reading && bit_count >= 6'h0F;
                mdio_out <= out_shift[16];
                if (reading && bit_count >= 6'h0F) out_shift <= {out_shift[15:0], 1'b0};
            end
            if (!reading) mdio_oe <= 1'b0;
        end
    end

    // ****************************************
    // Register bank and negotiation
    // ****************************************
    logic [15:0] basic_control;
    logic [15:0] advertise;
    // Ability snapshot taken at step one; later writes wait for a rerun
    logic [3:0] latched_adv;
    logic an_complete;
    logic page_rx;
    logic partner_able;
    logic [3:0] partner_tech;
    logic [1:0] an_step;
    logic an_run;
    logic res_speed;
    logic res_duplex;
    wire logic write_bc = wr_pulse && hdr_reg == REG_BASIC_CONTROL;
    wire logic write_adv = wr_pulse && hdr_reg == REG_ADVERTISE;
    wire logic an_on = basic_control[BC_AUTONEG]; // see [RULE_02]
    wire logic [3:0] common = latched_adv & PARTNER_TECH_ALL; // see [RULE_07] [RULE_10]
    // Nothing in common falls back to parallel detect at 100 half duplex
    wire logic none_common = (common == 4'h0);
    wire logic restart = (write_bc && shifter[BC_RESTART]) | digital_reset_req
                         | config_reload_req; // see [RULE_03] [RULE_04]
    always_ff @(posedge clock) begin
        bc_reset_pulse <= write_bc && shifter[BC_SOFT_RESET];
        if (bank_reset) begin
            basic_control <= BASIC_CONTROL_RST; // see [RULE_21]
            advertise <= ADVERTISE_RST; // see [RULE_08]
            an_run <= 1'b1; // see [RULE_04]
            an_step <= 2'h0;
            an_complete <= 1'b0;
            page_rx <= 1'b0;
            partner_able <= 1'b0;
            partner_tech <= 4'h0;
            latched_adv <= 4'h0;
            res_speed <= 1'b1;
            res_duplex <= 1'b1;
        end else begin
            // Reset and restart bits are stored as zero, so both read back cleared
            if (write_bc) basic_control <= {1'b0, shifter[14:10], 1'b0, shifter[8:0]};
            // Pause and abilities writable; next page, fault and T4 stay zero
            if (write_adv) advertise <= (shifter & ADV_WRITE_MASK) | {11'h000, SELECTOR_8023}; // see [RULE_11]
            if (restart) begin
                an_run <= 1'b1;
                an_step <= 2'h0;
                an_complete <= 1'b0;
                page_rx <= 1'b0;
            end else if (an_run && an_on) begin
                an_step <= an_step + 1'b1;
                case (an_step)
                    2'h0: begin
                        an_complete <= 1'b1; // see [RULE_05]
                        latched_adv <= advertise[ADV_TECH_LSB +: 4]; // see [RULE_09]
                    end
                    2'h1: page_rx <= 1'b1; // see [RULE_06]
                    default: begin
                        an_run <= 1'b0;
                        partner_able <= ~none_common; // see [RULE_12] [RULE_13]
                        partner_tech <= none_common ? PARALLEL_TECH : PARTNER_TECH_ALL;
                        res_speed <= common[3] | common[2] | none_common; // see [RULE_06]
                        res_duplex <= common[3] | (~common[2] & common[1]);
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Link result and flow control
    // ****************************************
    wire logic eff_speed = an_on ? res_speed : basic_control[BC_SPEED]; // see [RULE_14] [RULE_15]
    wire logic eff_duplex = an_on ? res_duplex : basic_control[BC_DUPLEX];
    wire logic sym = advertise[ADV_SYM_PAUSE]; // see [RULE_16]
    wire logic asym = advertise[ADV_ASYM_PAUSE];
    // Partner mirrors local pause, so resolution reduces to the local bits
    wire logic an_tx_pause = eff_duplex & (sym | asym); // see [RULE_17]
    wire logic an_rx_pause = eff_duplex & sym;
    wire logic use_manual = ~an_on | manual_flow_in[MF_SELECT]; // see [RULE_18] [RULE_19]
    // Both views are registered together, so the report never disagrees with the link
    always_ff @(posedge clock) begin
        if (hw_reset) begin
            link_state <= '0;
            host_port_manual_flow_reg <= '0;
        end else begin
            link_state.speed_100 <= eff_speed;
            link_state.full_duplex <= eff_duplex;
            link_state.tx_pause <= use_manual ? manual_flow_in[1] : an_tx_pause;
            link_state.rx_pause <= use_manual ? manual_flow_in[2] : an_rx_pause;
            host_port_manual_flow_reg <= {eff_duplex, use_manual ? manual_flow_in[2:1]
                                          : {an_rx_pause, an_tx_pause}, manual_flow_in[MF_SELECT]};
        end
    end

    // ****************************************
    // Read multiplexer
    // ****************************************
    wire logic [15:0] status_word = BASIC_STATUS_FIXED | {10'h000, an_complete, 5'h00};
    // Partner pause bits follow our advertisement, so any pause request is met when the link is full duplex
    wire logic [15:0] partner_word = {4'h0, asym, sym, 1'b0, partner_tech, SELECTOR_8023};
    always_comb begin
        case (hdr_reg)
            REG_BASIC_CONTROL: read_data = basic_control; // see [RULE_01]
            REG_BASIC_STATUS: read_data = status_word;
            REG_ID_HIGH: read_data = ID_HIGH_VALUE;
            REG_ID_LOW: read_data = ID_LOW_VALUE;
            REG_ADVERTISE: read_data = advertise;
            REG_PARTNER: read_data = partner_word;
            REG_EXPANSION: read_data = {14'h0000, page_rx, partner_able};
            // Absent registers read as all ones
            default: read_data = UNMAPPED_READ;
        endcase
    end

endmodule : epa_core

// ===== test/epa_core_sva.sv
// Port-level assertions for the emulated PHY core
`timescale 1ns/1ps
module epa_core_sva
    import epa_pkg::*;
#(
    parameter int RESET_CYCLES = 20
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Management link
    input wire logic mdc,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    // Controls
    input wire logic chip_rc_phy_reset_set,
    input wire logic pm_phy_reset_set,
    input wire logic [3:0] manual_flow_in,
    // Status
    input wire logic chip_rc_phy_reset,
    input wire logic pm_phy_reset,
    input wire epa_link_t link_state,
    input wire logic [3:0] host_port_manual_flow_reg
);
    logic [15:0] rc_cnt;
    logic [15:0] pm_cnt;
    logic [15:0] oe_cnt;
    always_ff @(posedge clock) begin
        rc_cnt <= (rst || !chip_rc_phy_reset) ? 16'h0 : rc_cnt + 16'h1;
        pm_cnt <= (rst || !pm_phy_reset) ? 16'h0 : pm_cnt + 16'h1;
        oe_cnt <= (rst || !mdio_oe) ? 16'h0 : oe_cnt + 16'h1;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Outputs lag inputs, so relations wait for three quiet cycles
    sequence s_flow_held;
        ($stable(manual_flow_in) && !$past(rst)) [*3];
    endsequence
    sequence s_all_held;
        ($stable(manual_flow_in) && $stable(link_state) && !$past(rst)) [*3];
    endsequence
    chk_rc_start: assert property (chip_rc_phy_reset_set |-> ##[1:2] chip_rc_phy_reset)
        else $error("reset control bit did not start");
    chk_rc_length: assert property ($fell(chip_rc_phy_reset) |-> rc_cnt == 16'(RESET_CYCLES))
        else $error("reset control bit held for wrong length");
    chk_pm_start: assert property (pm_phy_reset_set |-> ##[1:2] pm_phy_reset)
        else $error("power control bit did not start");
    chk_pm_length: assert property ($fell(pm_phy_reset) |-> pm_cnt == 16'(RESET_CYCLES))
        else $error("power control bit held for wrong length");
    chk_reset_quiet: assert property ($fell(rst) |-> !mdio_oe && link_state == '0)
        else $error("outputs active right after reset");
    chk_oe_bound: assert property (oe_cnt <= 16'h012C)
        else $error("data line driven too long");
    chk_mdio_edge: assert property (mdio_oe && $changed(mdio_out) |-> !mdc)
        else $error("read data changed while clock high");
    chk_manual_pause: assert property (s_flow_held ##0 manual_flow_in[0] |->
        link_state.tx_pause == manual_flow_in[1] && link_state.rx_pause == manual_flow_in[2])
        else $error("manual pause not applied");
    chk_flow_report: assert property (s_all_held |-> host_port_manual_flow_reg ==
        {link_state.full_duplex, link_state.rx_pause, link_state.tx_pause, manual_flow_in[0]})
        else $error("flow report differs from state");
endmodule : epa_core_sva
bind epa_core epa_core_sva #(.RESET_CYCLES(RESET_CYCLES)) epa_core_sva_inst (
    .clock(clock), .rst(rst), .mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .chip_rc_phy_reset_set(chip_rc_phy_reset_set), .pm_phy_reset_set(pm_phy_reset_set),
    .manual_flow_in(manual_flow_in), .chip_rc_phy_reset(chip_rc_phy_reset), .pm_phy_reset(pm_phy_reset),
    .link_state(link_state), .host_port_manual_flow_reg(host_port_manual_flow_reg)
);

// ===== test/epa_mac_model.sv
// Management master model standing in for the host-side MAC
`timescale 1ns/1ps
module epa_mac_model
    import epa_pkg::*;
(
    // Management link
    output logic mdc,
    output wire logic mdio_line,
    input wire logic mdio_out,
    input wire logic mdio_oe
);
    logic drv_oe = 1'b0;
    logic drv_val = 1'b0;
    int half_ns = 40;
    // Line has a pull-up, so a released line reads one
    assign mdio_line = drv_oe ? drv_val : (mdio_oe ? mdio_out : 1'b1);
    initial mdc = 1'b0;
    // Clock stands low between frames
    task automatic bit_cycle(input logic drive, input logic val, output logic got);
        drv_oe = drive;
        drv_val = val;
        #(half_ns);
        mdc = 1'b1;
        got = mdio_line;
        #(half_ns);
        mdc = 1'b0;
    endtask : bit_cycle
    task automatic frame(input epa_op_t op, input logic [4:0] phy, input logic [4:0] rg,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [31:0] hdr;
        logic got;
        hdr = {2'b01, op, phy, rg, 2'b10, wd};
        rd = 16'h0000;
        for (int i = 0; i < 32; i++) begin
            bit_cycle(1'b1, 1'b1, got);
        end
        for (int i = 31; i >= 0; i--) begin
            bit_cycle(op == OP_WRITE || i > 17, hdr[i], got);
            if (i < 16) rd = {rd[14:0], got};
        end
        drv_oe = 1'b0;
    endtask : frame
endmodule : epa_mac_model

// ===== test/testbench.sv
// Self-checking testbench for the emulated PHY core
`timescale 1ns/1ps
`define CHECK(got, exp) begin \
    checked++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("ERROR at %0t got %h expected %h", $time, got, exp); \
    end \
end
module testbench
    import epa_pkg::*;
;
    localparam int RESET_CYCLES = 20;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic hardware_reset_n = 1'b1;
    logic digital_reset_req = 1'b0;
    logic config_reload_req = 1'b0;
    logic chip_rc_phy_reset_set = 1'b0;
    logic pm_phy_reset_set = 1'b0;
    logic [4:0] phy_address = 5'h00;
    logic [3:0] manual_flow_in = 4'h0;
    logic mdc;
    wire logic mdio_line;
    logic mdio_out;
    logic mdio_oe;
    logic chip_rc_phy_reset;
    logic pm_phy_reset;
    epa_link_t link_state;
    logic [3:0] host_port_manual_flow_reg;
    logic [15:0] rdata;
    logic [3:0] tech;
    int error_cnt = 0;
    int checked = 0;
    int seed = 17;
    int n;
    always #4 clock = ~clock;
    epa_core #(.RESET_CYCLES(RESET_CYCLES)) epa_core_inst (
        .clock(clock), .rst(rst), .hardware_reset_n(hardware_reset_n), .mdc(mdc), .mdio_in(mdio_line),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .digital_reset_req(digital_reset_req),
        .config_reload_req(config_reload_req), .chip_rc_phy_reset_set(chip_rc_phy_reset_set),
        .pm_phy_reset_set(pm_phy_reset_set), .phy_address(phy_address), .manual_flow_in(manual_flow_in),
        .chip_rc_phy_reset(chip_rc_phy_reset), .pm_phy_reset(pm_phy_reset), .link_state(link_state),
        .host_port_manual_flow_reg(host_port_manual_flow_reg));
    epa_mac_model epa_mac_model_inst (.mdc(mdc), .mdio_line(mdio_line), .mdio_out(mdio_out), .mdio_oe(mdio_oe));
    function automatic logic [1:0] highest_common_ability(input logic [3:0] t);
        for (int b = 3; b >= 0; b--) begin
            if (t[b]) return 2'(b);
        end
        return 2'h2;
    endfunction : highest_common_ability
    task automatic wr(input logic [4:0] rg, input logic [15:0] wd);
        epa_mac_model_inst.frame(OP_WRITE, phy_address, rg, wd, rdata);
    endtask : wr
    task automatic rd(input logic [4:0] rg, output logic [15:0] d);
        epa_mac_model_inst.frame(OP_READ, phy_address, rg, 16'h0000, d);
    endtask : rd
    task automatic negotiate(input logic [3:0] t, input logic [1:0] pause);
        logic [15:0] adv;
        logic [15:0] d;
        adv = {4'h0, pause, 1'b0, t, SELECTOR_8023};
        wr(REG_ADVERTISE, adv);
        wr(REG_BASIC_CONTROL, 16'h1200);
        rd(REG_ADVERTISE, d);
        `CHECK(d, adv)
        rd(REG_EXPANSION, d);
        `CHECK(d[1:0], {1'b1, t != 4'h0})
        rd(REG_PARTNER, d);
        `CHECK(d[11:5], {pause, 1'b0, (t != 4'h0) ? PARTNER_TECH_ALL : PARALLEL_TECH})
        rd(REG_BASIC_STATUS, d);
        `CHECK({d[15], d[BS_AN_COMPLETE]}, 2'h1)
        `CHECK({link_state.speed_100, link_state.full_duplex}, highest_common_ability(t))
    endtask : negotiate
    task automatic stop_test;
        if (error_cnt == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test
    initial begin
        phy_address = 5'($random(seed));
        repeat (8) @(negedge clock);
        rst = 1'b0;
        epa_mac_model_inst.half_ns = 48;
        rd(REG_BASIC_CONTROL, rdata);
        `CHECK(rdata, BASIC_CONTROL_RST)
        epa_mac_model_inst.half_ns = 40;
        rd(REG_ADVERTISE, rdata);
        `CHECK(rdata, ADVERTISE_RST)
        rd(5'h10, rdata);
        `CHECK(rdata, UNMAPPED_READ)
        rd(REG_ID_HIGH, rdata);
        `CHECK(rdata, ID_HIGH_VALUE)
        rd(REG_ID_LOW, rdata);
        `CHECK(rdata, ID_LOW_VALUE)
        epa_mac_model_inst.frame(epa_op_t'(2'h3), phy_address, REG_BASIC_CONTROL, 16'h0000, rdata);
        `CHECK(rdata, 16'hFFFF)
        epa_mac_model_inst.frame(OP_READ, phy_address + 5'h1, REG_BASIC_CONTROL, 16'h0000, rdata);
        `CHECK(rdata, 16'hFFFF)
        for (int i = 0; i < 6; i++) begin
            tech = (i == 0) ? 4'h0 : 4'($random(seed));
            @(negedge clock);
            manual_flow_in = {1'b0, 3'($random(seed))};
            negotiate(tech, 2'($random(seed)));
            if (manual_flow_in[0]) `CHECK({link_state.rx_pause, link_state.tx_pause}, manual_flow_in[2:1])
        end
        @(negedge clock);
        manual_flow_in = 4'h0;
        // Digital reset, reload and each soft reset, then a fresh default negotiation
        for (int k = 0; k < 5; k++) begin
            negotiate(4'h1, 2'h0);
            wr(REG_ADVERTISE, ADVERTISE_RST);
            `CHECK({link_state.speed_100, link_state.full_duplex}, 2'h0)
            @(negedge clock);
            case (k)
                0: digital_reset_req = 1'b1;
                1: config_reload_req = 1'b1;
                2: chip_rc_phy_reset_set = 1'b1;
                3: pm_phy_reset_set = 1'b1;
                default: wr(REG_BASIC_CONTROL, 16'h8000);
            endcase
            n = 0;
            for (int c = 0; c < 200; c++) begin
                @(negedge clock);
                if (c == 0) {digital_reset_req, config_reload_req, chip_rc_phy_reset_set, pm_phy_reset_set} = 4'h0;
                if (chip_rc_phy_reset || pm_phy_reset) n++;
            end
            `CHECK(n, (k == 2 || k == 3) ? RESET_CYCLES : 0)
            rd(REG_BASIC_CONTROL, rdata);
            `CHECK(rdata[BC_SOFT_RESET], 1'b0)
            `CHECK({link_state.speed_100, link_state.full_duplex}, 2'h3)
        end
        for (int f = 0; f < 4; f++) begin
            @(negedge clock);
            manual_flow_in = {1'b0, f[1], f[0], 1'b0};
            wr(REG_BASIC_CONTROL, {2'h0, f[1], 4'h0, f[0], 8'h00});
            repeat (4) @(negedge clock);
            `CHECK({link_state.speed_100, link_state.full_duplex}, f[1:0])
            `CHECK({link_state.rx_pause, link_state.tx_pause}, f[1:0])
            `CHECK(host_port_manual_flow_reg, {f[0], f[1], f[0], 1'b0})
        end
        negotiate(4'hF, 2'h3);
        @(negedge clock);
        hardware_reset_n = 1'b0;
        repeat (4) @(negedge clock);
        hardware_reset_n = 1'b1;
        repeat (4) @(negedge clock);
        rd(REG_ADVERTISE, rdata);
        `CHECK(rdata, ADVERTISE_RST)
        stop_test();
    end
endmodule : testbench
